//--- test/cdr_i2c_host.sv
`timescale 1ns/10ps

module cdr_i2c_host (
    input wire clk,
    input wire devPull,
    output logic sck,
    output logic sda
);
    // Host pull-down request on the data wire
    logic hostPull = 1'b0;
    // Bus clock stands high between frames
    initial sck = 1'b1;
    // Open-drain wire with pull-up
    assign sda = !(hostPull || devPull);

    // Clock steps, just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic start();
        // Wait out the slave's late release before raising the clock
        hostPull = 1'b0;
        tick(4);
        sck = 1'b1;
        tick(2);
        hostPull = 1'b1;
        tick(2);
        sck = 1'b0;
        tick(2);
    endtask

    task automatic stop();
        hostPull = 1'b1;
        tick(4);
        sck = 1'b1;
        tick(2);
        hostPull = 1'b0;
        tick(4);
    endtask

    // One 80 ns slot: six steps low so the slave settles, two high
    task automatic bitx(input logic b, output logic s);
        hostPull = !b;
        tick(4);
        sck = 1'b1;
        tick(1);
        s = sda;
        tick(1);
        sck = 1'b0;
        tick(2);
    endtask

    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, s);
        ack = !s;
    endtask

    task automatic get(input logic ackIt, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, s);
            d[i] = s;
        end
        bitx(!ackIt, s);
    endtask
endmodule

//--- test/cdr_lock_chk.sv
`timescale 1ns/10ps

module cdr_lock_chk (
    input wire clk,
    input wire rst,
    input wire sckIn,
    input wire sdaOut,
    input wire sdaOe,
    input wire [15:0] freqErrorRefPpm,
    input wire [15:0] freqErrorDataPpm,
    input wire lossOfLockOut,
    input wire phaseLoopEnable,
    input wire referenceAcqMode,
    input wire freqAcqStart,
    input wire dataOutputOff,
    input wire clockOutputOff,
    input wire dataForceConstant
);
    // One domain, disabled in reset
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_clk_off; dataOutputOff |-> clockOutputOff; endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock on with data off");
    property p_squelch; dataForceConstant |-> !dataOutputOff; endproperty
    a_squelch: assert property (p_squelch) else $error("squelch while off");
    property p_open_drain; !sdaOut; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    property p_sda_low; $changed(sdaOe) |-> !sckIn; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data moved in clock high");
    property p_ref_loss;
        referenceAcqMode && freqErrorRefPpm > 16'd1000 ##1 referenceAcqMode[*2]
            |-> !phaseLoopEnable;
    endproperty
    a_ref_loss: assert property (p_ref_loss) else $error("lock kept over 1000");
    property p_data_loss;
        !referenceAcqMode && freqErrorDataPpm > 16'd1000 ##1 (!referenceAcqMode)[*2]
            |-> !phaseLoopEnable;
    endproperty
    a_data_loss: assert property (p_data_loss) else $error("lock kept over 1000");
    property p_ref_lock;
        (referenceAcqMode && freqErrorRefPpm <= 16'd250 && !freqAcqStart)[*4]
            |-> phaseLoopEnable;
    endproperty
    a_ref_lock: assert property (p_ref_lock) else $error("no lock within 250");
    property p_pin_loss; $fell(phaseLoopEnable) |-> lossOfLockOut; endproperty
    a_pin_loss: assert property (p_pin_loss) else $error("pin low after lock loss");
    property p_pulse; freqAcqStart |=> !freqAcqStart; endproperty
    a_pulse: assert property (p_pulse) else $error("restart pulse too long");
endmodule

//--- test/cdr_lock_ctrl_i2c_slave_tb.sv
`timescale 1ns/10ps
`include "cdr_defines.vh"

module cdr_lock_ctrl_i2c_slave_tb;
    logic clk, rst, sck, sda, sdaOut, sdaOe, sel, harm, tr, ackBit;
    logic loss_of_lock_out, ple, refMode, acqStart, fast, bufPdn, datOff, clkOff, frc, pol;
    logic [15:0] refErr, datErr;
    logic [1:0] range;
    logic [3:0] ratio;
    logic [7:0] aw;
    int failures = 0;
    int checked = 0;
    int starts = 0;
    int k;
    // Output control values and expected {off, clock off, squelch, polarity}
    logic [7:0] outv[4] = '{8'h10, 8'h08, 8'h22, 8'h32};
    logic [7:0] outx[4] = '{8'h0c, 8'h04, 8'h03, 8'h0d};
    // Write address byte for the strapped select
    assign aw = {`CDR_SLAVE_ADDR_HI, sel, 1'b0};

    cdr_lock_ctrl_i2c_slave #(.HARM_TRANSITIONS(16)) dut (
        .clk(clk), .rst(rst), .sckIn(sck), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrSelectPin(sel), .freqErrorRefPpm(refErr), .freqErrorDataPpm(datErr),
        .harmonicHint(harm), .dataTransition(tr), .lossOfLockOut(loss_of_lock_out),
        .phaseLoopEnable(ple), .referenceAcqMode(refMode), .freqAcqStart(acqStart),
        .fastAcqEnable(fast), .referenceBufferPowerdown(bufPdn),
        .referenceRangeField(range), .dataReferenceRatio(ratio), .dataOutputOff(datOff),
        .clockOutputOff(clkOff), .dataForceConstant(frc), .dataPolarityInvert(pol));
    cdr_i2c_host host (.clk(clk), .devPull(sdaOe), .sck(sck), .sda(sda));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Counts restart pulses
    always @(posedge clk) if (acqStart === 1'b1) starts <= starts + 1;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Write n bytes from a subaddress
    task automatic wr(input logic [7:0] sub, input logic [15:0] d, input int n);
        host.start();
        host.put(aw, ackBit);
        chk("ackAddr", 8'(ackBit), 8'h01);
        host.put(sub, ackBit);
        chk("ackSub", 8'(ackBit), 8'h01);
        for (int i = 0; i < n; i++) host.put(i ? d[7:0] : d[15:8], ackBit);
        host.stop();
        cyc(3);
    endtask
    // Read n bytes after a repeated start
    task automatic rd(input logic [7:0] sub, input logic [23:0] e, input int n);
        logic [7:0] v;
        host.start();
        host.put(aw, ackBit);
        host.put(sub, ackBit);
        host.start();
        host.put(aw | 8'h01, ackBit);
        for (int i = 0; i < n; i++) begin
            host.get(i < n - 1, v);
            chk("readData", v, e[23 - 8 * i -: 8]);
        end
        host.stop();
    endtask
    // Bounded wait for lock, gives up to the report
    task automatic waitLock();
        for (int i = 0; i < 50 && ple !== 1'b1; i++) cyc(1);
        chk("lockWait", 8'(ple), 8'h01);
        if (ple !== 1'b1) close_out();
    endtask
    task automatic trans(input int n);
        repeat (n) begin
            tr = 1'b1;
            cyc(1);
            tr = 1'b0;
            cyc(1);
        end
    endtask

    initial begin
        rst = 1'b1;
        sel = 1'b1;
        harm = 1'b0;
        tr = 1'b0;
        refErr = 16'd2000;
        datErr = 16'd2000;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        cyc(4);
        chk("resetPins", {6'h00, loss_of_lock_out, bufPdn}, 8'h03);
        rd(`CDR_ADDR_CONTROL_A, {`CDR_RST_CONTROL_A, `CDR_RST_CONTROL_B, `CDR_RST_CONTROL_C}, 3);
        rd(`CDR_ADDR_REF_SETUP, {`CDR_RST_REF_SETUP, 16'h0000}, 1);
        // Output disable and squelch combinations
        for (int i = 0; i < 4; i++) begin
            wr(`CDR_ADDR_OUTPUT_CTRL, {outv[i], 8'h00}, 1);
            chk("outPins", {4'h0, datOff, clkOff, frc, pol}, outx[i]);
        end
        rd(`CDR_ADDR_OUTPUT_CTRL, 24'h323232, 3);
        wr(`CDR_ADDR_REF_SETUP, 16'h2600, 1);
        wr(`CDR_ADDR_CONTROL_B, 16'h0001, 2);
        chk("setupPins", {range, ratio, fast, bufPdn}, 8'h9a);
        // Foreign address, bad subaddress, stray stop
        host.start();
        host.put(aw ^ 8'h02, ackBit);
        chk("ackOther", 8'(ackBit), 8'h00);
        host.stop();
        host.start();
        host.put(aw, ackBit);
        host.put(8'h07, ackBit);
        chk("ackBadSub", 8'(ackBit), 8'h00);
        host.stop();
        host.start();
        host.put(aw, ackBit);
        host.put(`CDR_ADDR_REF_SETUP, ackBit);
        repeat (3) host.bitx(1'b1, ackBit);
        host.stop();
        rd(`CDR_ADDR_REF_SETUP, 24'h260000, 1);
        // Normal mode lock with hysteresis
        datErr = 16'd100;
        waitLock();
        datErr = 16'd2000;
        cyc(2);
        datErr = 16'd500;
        cyc(4);
        chk("dataLoss", {6'h00, ple, loss_of_lock_out}, 8'h01);
        datErr = 16'd100;
        waitLock();
        rd(`CDR_ADDR_LOCK_STATUS, 24'h040000, 1);
        wr(`CDR_ADDR_CONTROL_B, 16'h1000, 1);
        chk("pinStatic", 8'(loss_of_lock_out), 8'h01);
        wr(`CDR_ADDR_CONTROL_A, 16'h0400, 1);
        wr(`CDR_ADDR_CONTROL_A, 16'h0000, 1);
        chk("pinCleared", 8'(loss_of_lock_out), 8'h00);
        rd(`CDR_ADDR_LOCK_STATUS, 24'h000000, 1);
        // Harmonic found on the last transition only
        harm = 1'b1;
        trans(15);
        cyc(3);
        chk("harmEarly", 8'(loss_of_lock_out), 8'h00);
        trans(1);
        cyc(3);
        chk("harmFound", {6'h00, ple, loss_of_lock_out}, 8'h03);
        harm = 1'b0;
        // Reference mode, data error ignored
        datErr = 16'd2000;
        refErr = 16'd100;
        wr(`CDR_ADDR_CONTROL_A, 16'h2000, 1);
        chk("refMode", 8'(refMode), 8'h01);
        waitLock();
        wr(`CDR_ADDR_CONTROL_A, 16'h2400, 1);
        wr(`CDR_ADDR_CONTROL_A, 16'h2000, 1);
        harm = 1'b1;
        trans(20);
        cyc(3);
        chk("harmOff", 8'(loss_of_lock_out), 8'h00);
        harm = 1'b0;
        refErr = 16'd1500;
        cyc(2);
        refErr = 16'd500;
        cyc(4);
        chk("refLoss", {6'h00, ple, loss_of_lock_out}, 8'h01);
        refErr = 16'd100;
        waitLock();
        // Start bit 1 then 0 restarts once
        k = starts;
        wr(`CDR_ADDR_CONTROL_B, 16'h5000, 1);
        wr(`CDR_ADDR_CONTROL_B, 16'h1000, 1);
        chk("restarts", 8'(starts - k), 8'h01);
        close_out();
    end
endmodule

bind cdr_lock_ctrl_i2c_slave cdr_lock_chk chk (.clk(clk), .rst(rst), .sckIn(sckIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .freqErrorRefPpm(freqErrorRefPpm),
    .freqErrorDataPpm(freqErrorDataPpm), .lossOfLockOut(lossOfLockOut),
    .phaseLoopEnable(phaseLoopEnable), .referenceAcqMode(referenceAcqMode),
    .freqAcqStart(freqAcqStart), .dataOutputOff(dataOutputOff),
    .clockOutputOff(clockOutputOff), .dataForceConstant(dataForceConstant));

//--- verilog/cdr_defines.vh
`ifndef CDR_DEFINES_VH
`define CDR_DEFINES_VH

// Register subaddresses
`define CDR_ADDR_LOCK_STATUS 8'h06
`define CDR_ADDR_CONTROL_A 8'h08
`define CDR_ADDR_CONTROL_B 8'h09
`define CDR_ADDR_CONTROL_C 8'h0a
`define CDR_ADDR_REF_SETUP 8'h0f
`define CDR_ADDR_OUTPUT_CTRL 8'h1e
`define CDR_ADDR_HIGHEST 8'h1e

// Reset values
`define CDR_RST_CONTROL_A 8'h00
`define CDR_RST_CONTROL_B 8'h00
`define CDR_RST_CONTROL_C 8'h04
`define CDR_RST_REF_SETUP 8'h00
`define CDR_RST_OUTPUT_CTRL 8'h00

// Field positions
`define RECOVERY_MODE_FIELD_MSB 6
`define RECOVERY_MODE_FIELD_LSB 4
`define RECOVERY_MODE_FIELD_REFERENCE 3'h2
`define CDR_BIT_CLEAR_STATIC 2
`define CDR_BIT_START_ACQ 6
`define CDR_BIT_LOCK_PIN_CFG 4
`define CDR_BIT_REF_PDN 2
`define CDR_BIT_FAST_ACQ 0
`define CDR_RANGE_MSB 5
`define CDR_RANGE_LSB 4
`define CDR_RATIO_MSB 3
`define CDR_RATIO_LSB 0
`define CDR_BIT_SQUELCH 5
`define CDR_BIT_DATA_OFF 4
`define CDR_BIT_CLOCK_OFF 3
`define CDR_BIT_POLARITY 1
`define CDR_BIT_STATIC_LOL 2
`define CDR_BIT_LIVE_LOL 3

// Slave address, upper six bits
`define CDR_SLAVE_ADDR_HI 6'h20

// Lock detector thresholds in ppm
`define CDR_LOCK_PPM 16'd250
`define CDR_UNLOCK_PPM 16'd1000

// Harmonic detect window in data transitions
`define CDR_HARM_TRANSITIONS 65536

`endif

//--- verilog/cdr_lock_ctrl_i2c_slave.v
`timescale 1ns/10ps
`include "cdr_defines.vh"


module cdr_lock_ctrl_i2c_slave #(
    parameter HARM_TRANSITIONS = `CDR_HARM_TRANSITIONS
) (
    clk,
    rst,
    sckIn,
    sdaIn,
    sdaOut,
    sdaOe,
    addrSelectPin,
    freqErrorRefPpm,
    freqErrorDataPpm,
    harmonicHint,
    dataTransition,
    lossOfLockOut,
    phaseLoopEnable,
    referenceAcqMode,
    freqAcqStart,
    fastAcqEnable,
    referenceBufferPowerdown,
    referenceRangeField,
    dataReferenceRatio,
    dataOutputOff,
    clockOutputOff,
    dataForceConstant,
    dataPolarityInvert
);
    input wire clk;
    input wire rst;
    input wire sckIn;
    input wire sdaIn;
    output reg sdaOut;
    output reg sdaOe;
    input wire addrSelectPin;
    input wire [15:0] freqErrorRefPpm;
    input wire [15:0] freqErrorDataPpm;
    input wire harmonicHint;
    input wire dataTransition;
    output reg lossOfLockOut;
    output reg phaseLoopEnable;
    output reg referenceAcqMode;
    output reg freqAcqStart;
    output reg fastAcqEnable;
    output reg referenceBufferPowerdown;
    output reg [1:0] referenceRangeField;
    output reg [3:0] dataReferenceRatio;
    output reg dataOutputOff;
    output reg clockOutputOff;
    output reg dataForceConstant;
    output reg dataPolarityInvert;

    // One-hot bus states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_SUB = 5'h04;
    localparam [4:0] ST_WDATA = 5'h08;
    localparam [4:0] ST_RDATA = 5'h10;

    // Last count of the harmonic window, cut to the counter width
    localparam [31:0] HARM_LAST_WIDE = HARM_TRANSITIONS - 1;
    localparam [16:0] HARM_LAST = HARM_LAST_WIDE[16:0];

    // Filtered bus lines and address select pin
    wire sckLevel;
    wire sckRise;
    wire sckFall;
    wire sdaLevel;
    wire sdaRise;
    wire sdaFall;
    wire addrSelect;

    // Control registers
    reg [7:0] recoveryControlA;
    reg [7:0] recoveryControlB;
    reg [7:0] recoveryControlC;
    reg [7:0] referenceLockSetup;
    reg [7:0] outputControl;

    // Bus engine state
    reg [4:0] state;
    reg [3:0] bitCnt;
    reg [7:0] rxShift;
    reg [7:0] txShift;
    reg [7:0] subAddr;
    reg readDir;

    // Lock detector state
    reg locked;
    reg staticLol;
    reg [16:0] harmCount;
    reg clearStaticPulse;
    reg startAcqPulse;
    reg modeChangePulse;

    // Combinational helpers
    reg [7:0] readByte;
    wire refMode;
    wire [15:0] activeError;
    wire harmonicFound;
    wire restartAcq;
    wire [7:0] nextSubAddr;

    // Mapped subaddress check, used only by the subaddress ack path
    function isMapped;
        input [7:0] addr;
        begin
            isMapped = (addr == `CDR_ADDR_LOCK_STATUS) || (addr == `CDR_ADDR_CONTROL_A) ||
                (addr == `CDR_ADDR_CONTROL_B) || (addr == `CDR_ADDR_CONTROL_C) ||
                (addr == `CDR_ADDR_REF_SETUP) || (addr == `CDR_ADDR_OUTPUT_CTRL);
        end
    endfunction

    cdr_pin_filter sckFilter (
        .clk(clk),
        .rst(rst),
        .pinIn(sckIn),
        .level(sckLevel),
        .rise(sckRise),
        .fall(sckFall)
    );

    cdr_pin_filter sdaFilter (
        .clk(clk),
        .rst(rst),
        .pinIn(sdaIn),
        .level(sdaLevel),
        .rise(sdaRise),
        .fall(sdaFall)
    );

    cdr_pin_filter selFilter (
        .clk(clk),
        .rst(rst),
        .pinIn(addrSelectPin),
        .level(addrSelect),
        .rise(),
        .fall()
    );

    assign refMode = (recoveryControlA[`RECOVERY_MODE_FIELD_MSB:`RECOVERY_MODE_FIELD_LSB] == `RECOVERY_MODE_FIELD_REFERENCE);
    assign activeError = refMode ? freqErrorRefPpm : freqErrorDataPpm;
    // harmonic window only outside reference mode
    assign harmonicFound = harmonicHint && locked && !refMode &&
        dataTransition && (harmCount == HARM_LAST);
    assign restartAcq = startAcqPulse || modeChangePulse;
    // read address saturates at the top
    assign nextSubAddr = (subAddr >= `CDR_ADDR_HIGHEST) ? `CDR_ADDR_HIGHEST : subAddr + 8'h01;

    // Read data for the current subaddress
    always @* begin
        case (subAddr)
            `CDR_ADDR_LOCK_STATUS: begin
                readByte = 8'h00;
                readByte[`CDR_BIT_STATIC_LOL] = staticLol;
                readByte[`CDR_BIT_LIVE_LOL] = ~locked;
            end
            `CDR_ADDR_CONTROL_A: readByte = recoveryControlA;
            `CDR_ADDR_CONTROL_B: readByte = recoveryControlB;
            `CDR_ADDR_CONTROL_C: readByte = recoveryControlC;
            `CDR_ADDR_REF_SETUP: readByte = referenceLockSetup;
            `CDR_ADDR_OUTPUT_CTRL: readByte = outputControl;
            default: readByte = 8'h00;
        endcase
    end

    // Serial engine and register writes
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            subAddr <= 8'h00;
            readDir <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            recoveryControlA <= `CDR_RST_CONTROL_A;
            recoveryControlB <= `CDR_RST_CONTROL_B;
            recoveryControlC <= `CDR_RST_CONTROL_C;
            referenceLockSetup <= `CDR_RST_REF_SETUP;
            outputControl <= `CDR_RST_OUTPUT_CTRL;
            clearStaticPulse <= 1'b0;
            startAcqPulse <= 1'b0;
            modeChangePulse <= 1'b0;
        end else begin
            clearStaticPulse <= 1'b0;
            startAcqPulse <= 1'b0;
            modeChangePulse <= 1'b0;
            sdaOut <= 1'b0;
            // start seen anywhere restarts address phase
            if (sdaFall && sckLevel) begin
                state <= ST_ADDR;
                bitCnt <= 4'h0;
                sdaOe <= 1'b0;
            // stop seen anywhere returns to idle
            end else if (sdaRise && sckLevel) begin
                state <= ST_IDLE;
                bitCnt <= 4'h0;
                sdaOe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    ST_ADDR, ST_SUB, ST_WDATA: begin
                        if (sckRise && (bitCnt < 4'h8)) begin
                            rxShift <= {rxShift[6:0], sdaLevel};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sckFall && (bitCnt == 4'h8)) begin
                            if (state == ST_ADDR) begin
                                if (rxShift[7:1] == {`CDR_SLAVE_ADDR_HI, addrSelect}) begin
                                    sdaOe <= 1'b1;
                                    readDir <= rxShift[0];
                                    bitCnt <= 4'h9;
                                end else begin
                                    state <= ST_IDLE;
                                    bitCnt <= 4'h0;
                                end
                            end else if (state == ST_SUB) begin
                                if (isMapped(rxShift)) begin
                                    subAddr <= rxShift;
                                    sdaOe <= 1'b1;
                                    bitCnt <= 4'h9;
                                end else begin
                                    state <= ST_IDLE;
                                    bitCnt <= 4'h0;
                                end
                            end else begin
                                // Data byte accepted
                                sdaOe <= 1'b1;
                                bitCnt <= 4'h9;
                                subAddr <= subAddr + 8'h01;
                                case (subAddr)
                                    `CDR_ADDR_CONTROL_A: begin
                                        recoveryControlA <= rxShift;
                                        // one then zero clears static bit
                                        clearStaticPulse <=
                                            recoveryControlA[`CDR_BIT_CLEAR_STATIC] &&
                                            !rxShift[`CDR_BIT_CLEAR_STATIC];
                                        modeChangePulse <= (rxShift[`RECOVERY_MODE_FIELD_MSB:`RECOVERY_MODE_FIELD_LSB]
                                            != recoveryControlA[`RECOVERY_MODE_FIELD_MSB:`RECOVERY_MODE_FIELD_LSB]);
                                    end
                                    `CDR_ADDR_CONTROL_B: begin
                                        recoveryControlB <= rxShift;
                                        // Start bit completes 0-1-0
                                        startAcqPulse <= recoveryControlB[`CDR_BIT_START_ACQ] &&
                                            !rxShift[`CDR_BIT_START_ACQ];
                                    end
                                    `CDR_ADDR_CONTROL_C: recoveryControlC <= rxShift;
                                    `CDR_ADDR_REF_SETUP: referenceLockSetup <= rxShift;
                                    `CDR_ADDR_OUTPUT_CTRL: outputControl <= rxShift;
                                    default: begin
                                    end
                                endcase
                            end
                        end else if (sckFall && (bitCnt == 4'h9)) begin
                            // End of acknowledge slot
                            bitCnt <= 4'h0;
                            sdaOe <= 1'b0;
                            if (state == ST_ADDR) begin
                                if (readDir) begin
                                    state <= ST_RDATA;
                                    txShift <= {readByte[6:0], 1'b0};
                                    sdaOe <= ~readByte[7];
                                    bitCnt <= 4'h1;
                                end else begin
                                    state <= ST_SUB;
                                end
                            end else begin
                                state <= ST_WDATA;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (sckFall && (bitCnt < 4'h8)) begin
                            // Next data bit, MSB first
                            sdaOe <= ~txShift[7];
                            txShift <= {txShift[6:0], 1'b0};
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sckFall && (bitCnt == 4'h8)) begin
                            // Release for master acknowledge
                            sdaOe <= 1'b0;
                            bitCnt <= 4'h9;
                        end else if (sckRise && (bitCnt == 4'h9)) begin
                            if (sdaLevel) begin
                                state <= ST_IDLE;
                                bitCnt <= 4'h0;
                            end else begin
                                subAddr <= nextSubAddr;
                                bitCnt <= 4'ha;
                            end
                        end else if (sckFall && (bitCnt == 4'ha)) begin
                            // Load and drive next byte
                            txShift <= {readByte[6:0], 1'b0};
                            sdaOe <= ~readByte[7];
                            bitCnt <= 4'h1;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                        bitCnt <= 4'h0;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Harmonic transition counter
    always @(posedge clk) begin
        if (rst) begin
            harmCount <= 17'h00000;
        // idle while in reference mode or unlocked
        end else if (!harmonicHint || !locked || refMode) begin
            harmCount <= 17'h00000;
        // count data transitions up to the window
        end else if (dataTransition) begin
            if (harmCount == HARM_LAST) begin
                harmCount <= 17'h00000;
            end else begin
                harmCount <= harmCount + 17'h00001;
            end
        end
    end

    // Lock detector with hysteresis and sticky flag
    always @(posedge clk) begin
        if (rst) begin
            locked <= 1'b0;
            staticLol <= 1'b0;
        end else begin
            if (!locked) begin
                if (!restartAcq && (activeError <= `CDR_LOCK_PPM)) begin
                    locked <= 1'b1;
                end
            // loss above 1000 ppm, harmonic forces reacquire
            end else if ((activeError > `CDR_UNLOCK_PPM) || harmonicFound || restartAcq) begin
                locked <= 1'b0;
            end
            if (locked && ((activeError > `CDR_UNLOCK_PPM) || harmonicFound || restartAcq)) begin
                staticLol <= 1'b1;
            end else if (clearStaticPulse) begin
                staticLol <= 1'b0;
            end
        end
    end

    // Registered outputs to analog and loops
    always @(posedge clk) begin
        if (rst) begin
            lossOfLockOut <= 1'b1;
            phaseLoopEnable <= 1'b0;
            referenceAcqMode <= 1'b0;
            freqAcqStart <= 1'b0;
            fastAcqEnable <= 1'b0;
            referenceBufferPowerdown <= 1'b1;
            referenceRangeField <= 2'h0;
            dataReferenceRatio <= 4'h0;
            dataOutputOff <= 1'b0;
            clockOutputOff <= 1'b0;
            dataForceConstant <= 1'b0;
            dataPolarityInvert <= 1'b0;
        end else begin
            // pin shows static or live state
            lossOfLockOut <= recoveryControlB[`CDR_BIT_LOCK_PIN_CFG] ? staticLol : ~locked;
            phaseLoopEnable <= locked;
            referenceAcqMode <= refMode;
            freqAcqStart <= restartAcq;
            fastAcqEnable <= recoveryControlC[`CDR_BIT_FAST_ACQ];
            referenceBufferPowerdown <= recoveryControlC[`CDR_BIT_REF_PDN];
            referenceRangeField <= referenceLockSetup[`CDR_RANGE_MSB:`CDR_RANGE_LSB];
            dataReferenceRatio <= referenceLockSetup[`CDR_RATIO_MSB:`CDR_RATIO_LSB];
            dataOutputOff <= outputControl[`CDR_BIT_DATA_OFF];
            // data disable takes the clock too
            clockOutputOff <= outputControl[`CDR_BIT_CLOCK_OFF] ||
                outputControl[`CDR_BIT_DATA_OFF];
            dataForceConstant <= outputControl[`CDR_BIT_SQUELCH] &&
                !outputControl[`CDR_BIT_DATA_OFF];
            dataPolarityInvert <= outputControl[`CDR_BIT_POLARITY];
        end
    end
endmodule

//--- verilog/cdr_pin_filter.v
`timescale 1ns/10ps

module cdr_pin_filter (
    clk,
    rst,
    pinIn,
    level,
    rise,
    fall
);
    input wire clk;
    input wire rst;
    input wire pinIn;
    output reg level;
    output reg rise;
    output reg fall;

    // Three-stage sampler; stage one feeds stage two only
    reg stage1;
    reg stage2;
    reg stage3;

    // Sample chain, accept a change once stages two and three agree
    always @(posedge clk) begin
        if (rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
            level <= 1'b1;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            rise <= 1'b0;
            fall <= 1'b0;
            // Agreed new value
            if ((stage2 == stage3) && (stage3 != level)) begin
                level <= stage3;
                rise <= stage3;
                fall <= ~stage3;
            end
        end
    end
endmodule
